// ==== hw/gcm_bank.sv ====
// Bank of global clock elements: glitch-free selectors or gated buffers.
// Assumes all inputs are synchronous to MCLK; outputs are registered
// levels that reproduce the chosen input clock one MCLK later.
// An input clock faster than half of MCLK cannot be reproduced.
`timescale 1ns/1ns
`default_nettype none

module gcm_bank #(
   parameter int N = gcm_pkg::ELEM_COUNT
) (
   input wire logic MCLK,
   input wire logic RSTN,
   input wire logic [N-1:0] FIRST_CLOCK_INPUT,
   input wire logic [N-1:0] SECOND_CLOCK_INPUT,
   input wire gcm_pkg::gcm_ctl_s [N-1:0] CTL,
   input wire gcm_pkg::gcm_cfg_s [N-1:0] CFG,
   output logic [N-1:0] CLK_OUT,
   output logic [N-1:0] STOPPED
);

   // ------------------------------------------------------------
   // Helpers
   // ------------------------------------------------------------
   function automatic logic pick(input logic src, input logic a, input logic b);
      pick = src ? b : a;
   endfunction : pick

   function automatic logic at_idle(input logic lvl, input logic stop_high);
      at_idle = (lvl == stop_high);
   endfunction : at_idle

   gcm_pkg::gcm_state_e st [N];
   logic active [N];
   logic want_src [N];
   logic want_en [N];
   logic cur_lvl [N];
   logic new_lvl [N];
   logic leave [N];
   logic resume [N];

   genvar g;
   generate
      for (g = 0; g < N; g++) begin : g_elem

         // ------------------------------------------------------------
         // Requested source and enable
         // ------------------------------------------------------------
         always_comb begin
            // Gated buffer always uses the first input
            want_src[g] = CFG[g].gated ? gcm_pkg::SRC_FIRST : CTL[g].select;
            want_en[g] = CFG[g].gated ? CTL[g].enable : 1'h1;
            cur_lvl[g] = pick(active[g], FIRST_CLOCK_INPUT[g], SECOND_CLOCK_INPUT[g]);
            new_lvl[g] = pick(want_src[g], FIRST_CLOCK_INPUT[g], SECOND_CLOCK_INPUT[g]);
            // Only leave once the old clock sits at idle: no runt on the way out
            leave[g] = ((want_src[g] != active[g]) || !want_en[g]) &&
                       at_idle(cur_lvl[g], CFG[g].stop_high);
            // Only rejoin at idle, so the first edge out is a whole pulse
            resume[g] = want_en[g] && at_idle(new_lvl[g], CFG[g].stop_high);
         end

         // ------------------------------------------------------------
         // State
         // ------------------------------------------------------------
         // Park is the safe state: nothing leaves it until the new clock sits idle
         always_ff @(posedge MCLK) begin
            if (!RSTN) begin
               st[g] <= gcm_pkg::GCM_PARK;
            end else begin
               case (st[g])
                  gcm_pkg::GCM_RUN: begin
                     if (leave[g]) begin
                        st[g] <= gcm_pkg::GCM_PARK;
                     end
                  end
                  gcm_pkg::GCM_PARK: begin
                     if (resume[g]) begin
                        st[g] <= gcm_pkg::GCM_RUN;
                     end
                  end
                  default: st[g] <= gcm_pkg::GCM_PARK;
               endcase
            end
         end

         // Source is only swapped while parked, never mid-pulse
         always_ff @(posedge MCLK) begin
            if (!RSTN) begin
               active[g] <= gcm_pkg::RST_SOURCE;
            end else if (st[g] == gcm_pkg::GCM_PARK) begin
               active[g] <= want_src[g];
            end
         end

         // ------------------------------------------------------------
         // Output
         // ------------------------------------------------------------
         always_ff @(posedge MCLK) begin
            if (!RSTN) begin
               CLK_OUT[g] <= gcm_pkg::RST_OUT;
            end else if (st[g] == gcm_pkg::GCM_RUN && !leave[g]) begin
               CLK_OUT[g] <= cur_lvl[g];
            end else if (st[g] == gcm_pkg::GCM_PARK && resume[g]) begin
               CLK_OUT[g] <= new_lvl[g];
            end else begin
               CLK_OUT[g] <= CFG[g].stop_high;
            end
         end

         always_ff @(posedge MCLK) begin
            if (!RSTN) begin
               STOPPED[g] <= gcm_pkg::RST_STOPPED;
            end else if (st[g] == gcm_pkg::GCM_RUN) begin
               STOPPED[g] <= leave[g];
            end else begin
               STOPPED[g] <= !resume[g];
            end
         end

         // ------------------------------------------------------------
         // Checks
         // ------------------------------------------------------------
         property p_park_level;
            @(posedge MCLK) disable iff (!RSTN)
            (st[g] == gcm_pkg::GCM_PARK && !resume[g]) |=> (CLK_OUT[g] == $past(CFG[g].stop_high));
         endproperty
         a_park_level: assert property (p_park_level) else $error("Parked output not at stop level");

         property p_out_moves_only_running;
            @(posedge MCLK) disable iff (!RSTN)
            (st[g] == gcm_pkg::GCM_PARK && !resume[g]) ##1 (st[g] == gcm_pkg::GCM_PARK && !resume[g])
               |=> $stable(CLK_OUT[g]);
         endproperty
         a_out_moves_only_running: assert property (p_out_moves_only_running) else $error("Output moved while parked");

         property p_change_parks;
            @(posedge MCLK) disable iff (!RSTN)
            (st[g] == gcm_pkg::GCM_RUN && want_src[g] != active[g] && cur_lvl[g] == CFG[g].stop_high)
               |=> (st[g] == gcm_pkg::GCM_PARK);
         endproperty
         a_change_parks: assert property (p_change_parks) else $error("Selection change did not park");

         property p_enable_stops;
            @(posedge MCLK) disable iff (!RSTN)
            (CFG[g].gated && !CTL[g].enable && st[g] == gcm_pkg::GCM_RUN && cur_lvl[g] == CFG[g].stop_high)
               |=> (STOPPED[g] && CLK_OUT[g] == $past(CFG[g].stop_high));
         endproperty
         a_enable_stops: assert property (p_enable_stops) else $error("Enable low did not stop output");

         property p_rejoin_new_source;
            @(posedge MCLK) disable iff (!RSTN)
            (st[g] == gcm_pkg::GCM_PARK && resume[g])
               |=> (st[g] == gcm_pkg::GCM_RUN && active[g] == $past(want_src[g]));
         endproperty
         a_rejoin_new_source: assert property (p_rejoin_new_source) else $error("Did not rejoin selected clock");

         property p_leave_at_idle;
            @(posedge MCLK) disable iff (!RSTN)
            (st[g] == gcm_pkg::GCM_RUN ##1 st[g] == gcm_pkg::GCM_PARK)
               |-> (CLK_OUT[g] == $past(cur_lvl[g]));
         endproperty
         a_leave_at_idle: assert property (p_leave_at_idle) else $error("Left old clock off its idle level");

         // ------------------------------------------------------------
         // Checks: reset, running and parked behaviour
         // ------------------------------------------------------------
         // Reset level of the output may differ from the stop level
         property p_reset_values;
            @(posedge MCLK)
            !RSTN |=> (CLK_OUT[g] == gcm_pkg::RST_OUT && STOPPED[g] == gcm_pkg::RST_STOPPED);
         endproperty
         a_reset_values: assert property (p_reset_values) else $error("Reset values not applied");

         property p_run_follows;
            @(posedge MCLK) disable iff (!RSTN)
            (st[g] == gcm_pkg::GCM_RUN && !leave[g]) |=> (CLK_OUT[g] == $past(cur_lvl[g]));
         endproperty
         a_run_follows: assert property (p_run_follows) else $error("Running output lost its source");

         property p_run_clear;
            @(posedge MCLK) disable iff (!RSTN)
            (st[g] == gcm_pkg::GCM_RUN && !leave[g]) |=> !STOPPED[g];
         endproperty
         a_run_clear: assert property (p_run_clear) else $error("Stop flag set while running");

         property p_park_flag;
            @(posedge MCLK) disable iff (!RSTN)
            (st[g] == gcm_pkg::GCM_PARK && !resume[g]) |=> STOPPED[g];
         endproperty
         a_park_flag: assert property (p_park_flag) else $error("Stop flag low while parked");

         // Output leaves its idle level only while running: no partial pulse
         property p_rise_from_run;
            @(posedge MCLK) disable iff (!RSTN)
            (CLK_OUT[g] != CFG[g].stop_high && $past(CLK_OUT[g]) == $past(CFG[g].stop_high))
               |-> $past(st[g] == gcm_pkg::GCM_RUN);
         endproperty
         a_rise_from_run: assert property (p_rise_from_run) else $error("Output left idle while parked");

         property p_source_held;
            @(posedge MCLK) disable iff (!RSTN)
            (st[g] == gcm_pkg::GCM_RUN) |=> $stable(active[g]);
         endproperty
         a_source_held: assert property (p_source_held) else $error("Source swapped while running");

         property p_gated_first;
            @(posedge MCLK) disable iff (!RSTN)
            (CFG[g].gated && st[g] == gcm_pkg::GCM_PARK) |=> (active[g] == gcm_pkg::SRC_FIRST);
         endproperty
         a_gated_first: assert property (p_gated_first) else $error("Gated element not on first input");

         property p_hold_disabled;
            @(posedge MCLK) disable iff (!RSTN)
            (st[g] == gcm_pkg::GCM_PARK && !want_en[g]) |=> (st[g] == gcm_pkg::GCM_PARK);
         endproperty
         a_hold_disabled: assert property (p_hold_disabled) else $error("Left park while disabled");

         property p_rejoin_at_idle;
            @(posedge MCLK) disable iff (!RSTN)
            (st[g] == gcm_pkg::GCM_PARK ##1 st[g] == gcm_pkg::GCM_RUN)
               |-> (CLK_OUT[g] == $past(CFG[g].stop_high));
         endproperty
         a_rejoin_at_idle: assert property (p_rejoin_at_idle) else $error("Rejoined off the idle level");

      end
   endgenerate

endmodule : gcm_bank

`default_nettype wire

// ==== hw/gcm_pkg.sv ====
// Constants, types and configuration carrier for the global clock element bank.
// Assumes every clock, select and enable input is sampled on MCLK.
// Operation
// - Sixteen elements, each a two-input clock selector free of glitches and runts.
// - Selection may change any time; related or unrelated input clocks both switch cleanly.
// - Element may act as gated buffer; enable stops and resumes without partial pulse.
// - Stopped output holds the configured level, High or Low, while stopped; in reset it holds RST_OUT instead.
// - Each selector has two clock inputs and a select; fabric drives select or enable.
package gcm_pkg;

   // ------------------------------------------------------------
   // Sizes
   // ------------------------------------------------------------
   localparam int ELEM_COUNT = 16;
   localparam int QUADRANT_LIMIT = 8;

   // ------------------------------------------------------------
   // Reset values and first-source select code
   // ------------------------------------------------------------
   localparam logic RST_OUT = 1'h0;
   localparam logic RST_SOURCE = 1'h0;
   localparam logic RST_STOPPED = 1'h1;
   localparam logic SRC_FIRST = 1'h0;

   // ------------------------------------------------------------
   // Types
   // ------------------------------------------------------------
   typedef enum logic [0:0] {
      GCM_RUN = 1'b0,
      GCM_PARK = 1'b1
   } gcm_state_e;

   // Per-element configuration
   typedef struct packed {
      logic gated;       // 1: gated global buffer, 0: global clock selector
      logic stop_high;   // Level held while stopped or switching
   } gcm_cfg_s;

   // Per-element fabric controls
   typedef struct packed {
      logic select;      // Picks second_clock_input when high
      logic enable;      // Clock enable in gated mode
   } gcm_ctl_s;

endpackage : gcm_pkg

// ==== sim/gcm_fabric_model.sv ====
// Fabric-side clock sources that feed the element bank.
// Assumes the bank samples on MCLK rising edges; sources move on falling edges.
`timescale 1ns/1ns
`default_nettype none
module gcm_fabric_model #(
   parameter int N = 2
) (
   input wire logic MCLK,
   output logic [N-1:0] FIRST_CLOCK_INPUT,
   output logic [N-1:0] SECOND_CLOCK_INPUT
);
   int cnt = 0;
   always @(negedge MCLK) begin
      cnt <= (cnt + 1) % 12;
   end
   // Related periods 4 and 6 from one shared counter, one unshared pair per element
   always_comb begin
      for (int e = 0; e < N; e++) begin
         FIRST_CLOCK_INPUT[e] = ((cnt + e) % 4) < 2;
         SECOND_CLOCK_INPUT[e] = ((cnt + 2 * e) % 6) < 3;
      end
   end
endmodule : gcm_fabric_model
`default_nettype wire

// ==== sim/test_glitch_free_global_clock_mux.sv ====
// Self-checking bench for the global clock element bank.
// Assumes the bank's own assertions guard cycle detail; this bench judges at the ports.
`timescale 1ns/1ns
`default_nettype none
module test_glitch_free_global_clock_mux;
   localparam int N = 2;
   logic mclk = 1'h0;
   logic rstn = 1'h0;
   logic [N-1:0] first_in, second_in, clk_out, stopped;
   gcm_pkg::gcm_ctl_s [N-1:0] ctl = 4'h5;
   gcm_pkg::gcm_cfg_s [N-1:0] cfg = 4'h4;
   int err_total = 0;
   int checks_done = 0;
   int run_len [N];
   initial forever #10 mclk = ~mclk;
   gcm_bank #(.N(N)) gcm_bank_i (.MCLK(mclk), .RSTN(rstn), .FIRST_CLOCK_INPUT(first_in),
      .SECOND_CLOCK_INPUT(second_in), .CTL(ctl), .CFG(cfg), .CLK_OUT(clk_out), .STOPPED(stopped));
   gcm_fabric_model #(.N(N)) gcm_fabric_model_i (.MCLK(mclk), .FIRST_CLOCK_INPUT(first_in),
      .SECOND_CLOCK_INPUT(second_in));
   task automatic note(input string what, input logic exp, input logic got);
      checks_done++;
      if (exp !== got) begin
         err_total++;
         $display("[ERR] %s expected %b seen %b", what, exp, got);
      end
   endtask : note
   // Narrowest input half period is 2, so a 1-cycle pulse is a runt
   always @(negedge mclk) begin
      for (int e = 0; e < N; e++) begin
         if (!rstn || clk_out[e] === cfg[e].stop_high) begin
            if (rstn && run_len[e] == 1) note("pulse width", 1'h0, 1'h1);
            run_len[e] = 0;
         end else run_len[e]++;
      end
   end
   task automatic follow(input int cycles);
      logic [N-1:0] exp;
      repeat (cycles) begin
         // Sources move on falling edges, so take them at the sampling edge
         @(posedge mclk);
         for (int e = 0; e < N; e++) begin
            exp[e] = (ctl[e].select && !cfg[e].gated) ? second_in[e] : first_in[e];
         end
         @(negedge mclk);
         for (int e = 0; e < N; e++) begin
            note("stopped", 1'h0, stopped[e]);
            note("clock out", exp[e], clk_out[e]);
         end
      end
   endtask : follow
   task automatic parked(input int cycles);
      repeat (cycles) begin
         @(negedge mclk);
         for (int e = 0; e < N; e++) begin
            note("stopped", 1'h1, stopped[e]);
            note("stop level", cfg[e].stop_high, clk_out[e]);
         end
      end
   endtask : parked
   task automatic test_select();
      // Elements leave reset parked and join once their source is idle
      repeat (8) @(negedge mclk);
      follow(8);
      for (int k = 0; k < 3; k++) begin
         repeat (k + 1) @(negedge mclk);
         ctl <= 4'hf;
         repeat (16) @(negedge mclk);
         follow(12);
         ctl <= 4'h5;
         repeat (16) @(negedge mclk);
         follow(12);
      end
      $display("test_select done");
   endtask : test_select
   task automatic test_toggle();
      // Selection flips every cycle, often mid-pulse
      for (int k = 0; k < 11; k++) begin
         @(negedge mclk);
         ctl <= (k % 2) ? 4'h5 : 4'hf;
      end
      repeat (16) @(negedge mclk);
      follow(12);
      $display("test_toggle done");
   endtask : test_toggle
   task automatic test_gate();
      cfg <= 4'he;
      repeat (12) @(negedge mclk);
      follow(8);
      for (int k = 0; k < 2; k++) begin
         ctl <= 4'h0;
         repeat (8) @(negedge mclk);
         parked(10 + k);
         ctl <= 4'h5;
         repeat (12) @(negedge mclk);
         follow(12);
      end
      $display("test_gate done");
   endtask : test_gate
   task automatic test_reset();
      // Reset lands one cycle into a switch back to selector mode
      cfg <= 4'h4;
      ctl <= 4'hf;
      @(negedge mclk);
      rstn <= 1'h0;
      repeat (2) @(negedge mclk);
      for (int e = 0; e < N; e++) begin
         note("reset clock out", gcm_pkg::RST_OUT, clk_out[e]);
         note("reset stopped", gcm_pkg::RST_STOPPED, stopped[e]);
      end
      rstn <= 1'h1;
      repeat (8) @(negedge mclk);
      follow(12);
      $display("test_reset done");
   endtask : test_reset
   task automatic complete_run();
      $display("checks %0d mismatches %0d", checks_done, err_total);
      if (err_total == 0 && checks_done > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask : complete_run
   initial begin
      repeat (16) @(negedge mclk);
      rstn <= 1'h1;
      test_select();
      test_toggle();
      test_gate();
      test_reset();
      complete_run();
   end
   initial begin
      #40000;
      err_total++;
      $display("[ERR] watchdog expected done seen hang");
      complete_run();
   end
endmodule : test_glitch_free_global_clock_mux
`default_nettype wire
